//--- hdl/dich_core.sv
/*
 * Instruction code interpreter of a motor drive: decodes codes and data
 * words written by the network master, keeps parameters, selectors and
 * set frequency, and builds the six monitor result words.
 * Assumes an Avalon-MM master on mclk; running and powerFail are pins.
 */
// Function
// R1: HED stores frequency RAM; HEE also nonvolatile
// R2: Master uses HED for repeated frequency updates
// R3: Parameter read 00-63, write 80-E3
// R4: Writes to parameters 77, 79 refused
// R5: Master selects upper bank before parameter 100+
// R6: FFF0 means 8888, FFFF means 9999
// R7: Master sets parameter 342 for frequent writes
// R8: HF4 with 9696 clears fault history
// R9: HFC clears parameters; 9696 comm, 5A5A not
// R10: HFC 9966 full clear with comm; 55AA
// R11: Any clear resets HEC, HF3, HFF settings
// R12: Power loss during preserving clear resets comm
// R13: HFD with 9696 resets the drive
// R14: Selector H6C/HEC: 0 freq, 1, 2 analog
// R15: Bias/gain codes depend on extended setting
// R16: Selector access only with extended setting 1/9
// R17: HF3 write uses low byte only
// R18: 32-bit reads above FFFF return FFFF
// R19: Select word A low/high pick results 1/2
// R20: Code 00 low reads zero, high frequency
// R21: Monitor select words three to six independent
// R22: Frequency items ignore speed display scaling
// R23: Parameter 52 = 100: stopped shows set frequency
// R24: Refused accesses change nothing, flag rejection
`timescale 1ns/1ns
module dich_core (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire dich_pkg::dich_mon_t monIn,
	input wire logic running,
	input wire logic powerFail,
	output logic [15:0] setFreqRam,
	output logic faultClearPulse,
	output logic driveResetPulse,
	output logic nvStorePulse
);
	import dich_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	dich_state_t state_q, state_d;
	logic waitreq_q, waitreq_d;
	logic [31:0] rdata_q, rdata_d;
	logic [15:0] dataReg_q, dataReg_d;
	logic [7:0] lastCode_q, lastCode_d;
	logic [15:0] resp_q, resp_d;
	logic rejected_q, rejected_d;
	logic [7:0] extSet_q, extSet_d;
	logic [1:0] secondSel_q, secondSel_d;
	logic [7:0] hf3Sel_q, hf3Sel_d;
	logic [15:0] fRam_q, fRam_d;
	logic [15:0] fNv_q, fNv_d;
	logic ramOnly_q, ramOnly_d;
	logic pr52Follow_q, pr52Follow_d;
	logic [15:0] monSelA_q, monSelA_d;
	logic [3:0][15:0] monSelX_q, monSelX_d;
	logic [5:0][15:0] monRes_q, monRes_d;
	logic [8:0] clearCnt_q, clearCnt_d;
	logic clearComm_q, clearComm_d;
	logic faultClr_q, faultClr_d;
	logic driveRst_q, driveRst_d;
	logic nvStore_q, nvStore_d;
	logic runMeta_q, runSync_q, pfMeta_q, pfSync_q;
	logic [15:0] paramMem [0:511];
	logic memWe;
	logic [8:0] memAddr;
	logic [15:0] memWd;
	logic [1:0] bank;
	logic selOk;
	logic [15:0] freqWord;
	logic cmdFire;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	// Two stages each; only the second stage is read by logic
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			runMeta_q <= 1'b0;
			runSync_q <= 1'b0;
			pfMeta_q <= 1'b0;
			pfSync_q <= 1'b0;
		end else begin
			runMeta_q <= running;
			runSync_q <= runMeta_q;
			pfMeta_q <= powerFail;
			pfSync_q <= pfMeta_q;
		end
	end

	// ----------------------------------------------------------------
	// Bank and monitor helpers
	// ----------------------------------------------------------------
	// Bank 0 base, 1 upper and bias/gain, 2 bias/gain, 3 unusable
	always_comb begin
		if (extSet_q == RST_BYTE) begin
			bank = 2'd0;
		end else if (extSet_q == EXT_BANK1) begin
			bank = 2'd1; // [R15]
		end else if (extSet_q == EXT_BANK9) begin
			bank = 2'd2; // [R15]
		end else begin
			bank = 2'd3;
		end
	end
	assign selOk = (bank == 2'd1) || (bank == 2'd2); // [R16]

	// Stopped drive shows the set frequency when asked; raw 0.01 Hz, no scaling
	assign freqWord = (pr52Follow_q && !runSync_q) ? fRam_q : dichSat(monIn.outFreq); // [R23] [R22]

	// Live values come in as arguments so a continuous assign re-evaluates on them
	function automatic logic [15:0] monItem(input logic [7:0] c, input logic high,
		input logic [15:0] fw, input dich_mon_t m);
		logic [15:0] v;
		v = RST_WORD;
		if (c == MC_NONE) begin
			v = high ? fw : RST_WORD; // [R20]
		end else if (c == MC_FREQ) begin
			v = fw;
		end else if (c == MC_CURR) begin
			v = dichSat(m.outCurrent); // [R18]
		end else if (c == MC_VOLT) begin
			v = dichSat(m.outVoltage); // [R18]
		end
		return v;
	endfunction : monItem

	// ----------------------------------------------------------------
	// Monitor result words
	// ----------------------------------------------------------------
	// Result 1 and 2 share word A; results 3 to 6 each own a word
	for (genvar g = 0; g < 6; g++) begin : gMon
		logic [7:0] sel;
		if (g == 0) begin : gLow
			assign sel = monSelA_q[7:0]; // [R19]
		end else if (g == 1) begin : gHigh
			assign sel = monSelA_q[15:8]; // [R19]
		end else begin : gExt
			assign sel = monSelX_q[g - 2][7:0]; // [R21]
		end
		assign monRes_d[g] = monItem(sel, g == 1, freqWord, monIn);
	end

	// ----------------------------------------------------------------
	// Parameter store
	// ----------------------------------------------------------------
	// Plain array, no reset: cleared by the walking clear sequence
	always_ff @(posedge mclk) begin
		if (memWe) begin
			paramMem[memAddr] <= memWd;
		end
	end

	assign cmdFire = (state_q == S_IDLE) && avs_write && (avs_address == OFF_CODE);

	// ----------------------------------------------------------------
	// Bus slave and command interpreter, next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [7:0] code;
		logic [15:0] dat;
		code = avs_writedata[7:0];
		dat = dataReg_q;
		state_d = state_q;
		waitreq_d = 1'b1;
		rdata_d = rdata_q;
		dataReg_d = dataReg_q;
		lastCode_d = lastCode_q;
		resp_d = resp_q;
		rejected_d = rejected_q;
		extSet_d = extSet_q;
		secondSel_d = secondSel_q;
		hf3Sel_d = hf3Sel_q;
		fRam_d = fRam_q;
		fNv_d = fNv_q;
		ramOnly_d = ramOnly_q;
		pr52Follow_d = pr52Follow_q;
		monSelA_d = monSelA_q;
		monSelX_d = monSelX_q;
		clearCnt_d = clearCnt_q;
		clearComm_d = clearComm_q;
		faultClr_d = 1'b0;
		driveRst_d = 1'b0;
		nvStore_d = 1'b0;
		memWe = 1'b0;
		memAddr = 9'h000;
		memWd = RST_WORD;
		case (state_q)
			S_IDLE: begin
				if (avs_read || avs_write) begin
					state_d = S_ACK;
					waitreq_d = 1'b0;
				end
				if (cmdFire) begin
					lastCode_d = code;
					rejected_d = 1'b0;
					if (code <= IC_PRD_LAST) begin
						// Special values FFF0/FFFF pass through unchanged
						if (bank == 2'd3) begin
							rejected_d = 1'b1; // [R24]
						end else begin
							resp_d = paramMem[{bank, code[6:0]}]; // [R3] [R6]
						end
					end else if (code >= IC_PWR_FIRST && code <= IC_PWR_LAST) begin
						if (bank == 2'd3 || (bank == 2'd0 &&
							(code[6:0] == PN_PROT_A || code[6:0] == PN_PROT_B))) begin
							rejected_d = 1'b1; // [R4] [R24]
						end else begin
							memWe = 1'b1; // [R3] [R6]
							memAddr = {bank, code[6:0]};
							memWd = dat;
							nvStore_d = !ramOnly_q; // [R7]
							if (bank == 2'd0 && code[6:0] == PN_MONSEL) begin
								pr52Follow_d = (dat == PR52_FOLLOW); // [R23]
							end
						end
					end else begin
						case (code)
							IC_SEL_RD: begin
								if (selOk) begin
									resp_d = {14'h0000, secondSel_q}; // [R14]
								end else begin
									rejected_d = 1'b1; // [R16]
								end
							end
							IC_SEL_WR: begin
								if (selOk && dat <= {14'h0000, SEL_MAX}) begin
									secondSel_d = dat[1:0]; // [R14]
								end else begin
									rejected_d = 1'b1; // [R16] [R24]
								end
							end
							IC_FRAM_RD: resp_d = fRam_q;
							IC_FNV_RD: resp_d = fNv_q;
							IC_OFREQ_RD: resp_d = freqWord;
							IC_OCUR_RD: resp_d = dichSat(monIn.outCurrent); // [R18]
							IC_OVOLT_RD: resp_d = dichSat(monIn.outVoltage); // [R18]
							IC_SPMON_RD: resp_d = monItem(hf3Sel_q, 1'b0, freqWord, monIn);
							IC_SPSEL_RD: resp_d = {8'h00, hf3Sel_q};
							IC_EXT_RD: resp_d = {8'h00, extSet_q};
							IC_FRAM_WR, IC_FNV_WR: begin
								if (dat > FREQ_MAX) begin
									rejected_d = 1'b1; // [R1] [R24]
								end else begin
									fRam_d = dat; // [R1]
									if (code == IC_FNV_WR) begin
										fNv_d = dat; // [R1]
										nvStore_d = 1'b1;
									end
								end
							end
							IC_SPSEL_WR: hf3Sel_d = dat[7:0]; // [R17]
							IC_FAULT_CLR: begin
								if (dat == KEY_9696) begin
									faultClr_d = 1'b1; // [R8]
								end else begin
									rejected_d = 1'b1;
								end
							end
							IC_PCLEAR: begin
								if (dat == KEY_9696 || dat == KEY_9966 ||
									dat == KEY_5A5A || dat == KEY_55AA) begin
									// Hold the bus while every parameter word walks to zero
									state_d = S_CLEAR; // [R9] [R10]
									waitreq_d = 1'b1;
									clearCnt_d = 9'h000;
									clearComm_d = (dat == KEY_9696) || (dat == KEY_9966); // [R9] [R10]
									secondSel_d = 2'h0; // [R11]
									hf3Sel_d = RST_BYTE; // [R11]
									extSet_d = RST_BYTE; // [R11]
									pr52Follow_d = 1'b0;
									if ((dat == KEY_9696) || (dat == KEY_9966)) begin
										ramOnly_d = 1'b0; // [R9]
									end
								end else begin
									rejected_d = 1'b1;
								end
							end
							IC_DRV_RST: begin
								if (dat == KEY_9696) begin
									driveRst_d = 1'b1; // [R13]
								end else begin
									rejected_d = 1'b1;
								end
							end
							IC_EXT_WR: extSet_d = dat[7:0];
							default: rejected_d = 1'b1;
						endcase
					end
				end else if (avs_write) begin
					if (avs_address == OFF_DATA) begin
						dataReg_d = avs_writedata[15:0];
					end else if (avs_address == OFF_MONA) begin
						monSelA_d = avs_writedata[15:0]; // [R19]
					end else if (avs_address == OFF_FCMD) begin
						if (avs_writedata[15:0] > FREQ_MAX) begin
							rejected_d = 1'b1; // [R1]
						end else begin
							fRam_d = avs_writedata[15:0]; // [R1]
						end
					end else if (avs_address >= OFF_MON3 && avs_address <= OFF_MON6 &&
						avs_address[1:0] == 2'b00) begin
						monSelX_d[2'(avs_address[7:2] - OFF_MON3[7:2])] = avs_writedata[15:0]; // [R21]
					end else if (avs_address == OFF_CTRL) begin
						ramOnly_d = avs_writedata[0];
					end
				end else if (avs_read) begin
					rdata_d = 32'h0000_0000;
					if (avs_address == OFF_CODE) begin
						rdata_d = {24'h000000, lastCode_q};
					end else if (avs_address == OFF_DATA) begin
						rdata_d = {16'h0000, dataReg_q};
					end else if (avs_address == OFF_RESP) begin
						rdata_d = {16'h0000, resp_q};
					end else if (avs_address == OFF_STAT) begin
						rdata_d = {31'h00000000, rejected_q}; // [R24]
					end else if (avs_address == OFF_MONA) begin
						rdata_d = {16'h0000, monSelA_q};
					end else if (avs_address == OFF_FCMD) begin
						rdata_d = {16'h0000, fRam_q};
					end else if (avs_address >= OFF_MON3 && avs_address <= OFF_MON6 &&
						avs_address[1:0] == 2'b00) begin
						rdata_d = {16'h0000, monSelX_q[2'(avs_address[7:2] - OFF_MON3[7:2])]};
					end else if (avs_address >= OFF_RES1 && avs_address <= OFF_RES6 &&
						avs_address[1:0] == 2'b00) begin
						rdata_d = {16'h0000, monRes_q[3'(avs_address[7:2] - OFF_RES1[7:2])]};
					end else if (avs_address == OFF_CTRL) begin
						rdata_d = {31'h00000000, ramOnly_q};
					end
				end
			end
			S_ACK: begin
				state_d = S_IDLE;
			end
			S_CLEAR: begin
				memWe = 1'b1;
				memAddr = clearCnt_q;
				memWd = RST_WORD;
				clearCnt_d = 9'(clearCnt_q + 9'h001);
				// A preserving clear cut by power loss brings comm settings home
				if (pfSync_q && !clearComm_q) begin
					ramOnly_d = 1'b0; // [R12]
				end
				if (clearCnt_q == CLEAR_LAST) begin
					state_d = S_ACK;
					waitreq_d = 1'b0;
				end
			end
			default: state_d = S_IDLE;
		endcase
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= S_IDLE;
			waitreq_q <= 1'b1;
			rdata_q <= 32'h0000_0000;
			dataReg_q <= RST_WORD;
			lastCode_q <= RST_BYTE;
			resp_q <= RST_WORD;
			rejected_q <= 1'b0;
			extSet_q <= RST_BYTE;
			secondSel_q <= 2'h0;
			hf3Sel_q <= RST_BYTE;
			fRam_q <= RST_WORD;
			fNv_q <= RST_WORD;
			ramOnly_q <= 1'b0;
			pr52Follow_q <= 1'b0;
			monSelA_q <= RST_WORD;
			monSelX_q <= '0;
			monRes_q <= '0;
			clearCnt_q <= 9'h000;
			clearComm_q <= 1'b0;
			faultClr_q <= 1'b0;
			driveRst_q <= 1'b0;
			nvStore_q <= 1'b0;
		end else begin
			state_q <= state_d;
			waitreq_q <= waitreq_d;
			rdata_q <= rdata_d;
			dataReg_q <= dataReg_d;
			lastCode_q <= lastCode_d;
			resp_q <= resp_d;
			rejected_q <= rejected_d;
			extSet_q <= extSet_d;
			secondSel_q <= secondSel_d;
			hf3Sel_q <= hf3Sel_d;
			fRam_q <= fRam_d;
			fNv_q <= fNv_d;
			ramOnly_q <= ramOnly_d;
			pr52Follow_q <= pr52Follow_d;
			monSelA_q <= monSelA_d;
			monSelX_q <= monSelX_d;
			monRes_q <= monRes_d;
			clearCnt_q <= clearCnt_d;
			clearComm_q <= clearComm_d;
			faultClr_q <= faultClr_d;
			driveRst_q <= driveRst_d;
			nvStore_q <= nvStore_d;
		end
	end

	assign avs_readdata = rdata_q;
	assign avs_waitrequest = waitreq_q;
	assign setFreqRam = fRam_q;
	assign faultClearPulse = faultClr_q;
	assign driveResetPulse = driveRst_q;
	assign nvStorePulse = nvStore_q;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);

	sequence sFire(logic [7:0] c);
		cmdFire && avs_writedata[7:0] == c;
	endsequence

	sequence sAckNext;
		##1 (state_q == S_ACK && !avs_waitrequest);
	endsequence

	a_fault_clear: assert property (sFire(IC_FAULT_CLR) ##0 (dataReg_q == KEY_9696)
		|=> faultClearPulse ##1 !faultClearPulse) // [R8]
		else $error("fault clear pulse missing");
	a_drive_reset: assert property (driveResetPulse
		|-> $past(cmdFire && avs_writedata[7:0] == IC_DRV_RST && dataReg_q == KEY_9696)) // [R13]
		else $error("drive reset without its command");
	a_freq_range: assert property (sFire(IC_FRAM_WR) ##0 (dataReg_q > FREQ_MAX)
		|=> rejected_q && $stable(setFreqRam)) // [R1]
		else $error("out of range frequency accepted");
	a_protect_param: assert property (cmdFire && bank == 2'd0 &&
		avs_writedata[7:0] == (IC_PWR_FIRST | {1'b0, PN_PROT_A}) |=> rejected_q) // [R4]
		else $error("protected parameter write accepted");
	a_sel_gate: assert property (sFire(IC_SEL_WR) ##0 !selOk
		|=> rejected_q && secondSel_q == $past(secondSel_q)) // [R16]
		else $error("selector written outside bank 1 or 9");
	a_clear_sel: assert property (sFire(IC_PCLEAR) ##0 (dataReg_q == KEY_5A5A)
		|=> (state_q == S_CLEAR && hf3Sel_q == RST_BYTE && extSet_q == RST_BYTE
		&& secondSel_q == 2'h0)) // [R11]
		else $error("clear left selectors set");
	a_mon_none: assert property (monSelA_q[7:0] == MC_NONE && $stable(monSelA_q)
		|=> monRes_q[0] == RST_WORD) // [R20]
		else $error("code zero low result not zero");
	a_mon_sat: assert property (monSelA_q[15:8] == MC_CURR && monIn.outCurrent > 32'h0000_FFFF
		|=> monRes_q[1] == SAT_MAX) // [R18]
		else $error("current monitor not saturated");
	a_spsel_low: assert property (sFire(IC_SPSEL_WR) |=> hf3Sel_q == $past(dataReg_q[7:0])) // [R17]
		else $error("special monitor code not low byte");
	a_answer_time: assert property ((state_q == S_IDLE) && avs_read |-> sAckNext) // [R24]
		else $error("read not answered in one cycle");

endmodule : dich_core

//--- hdl/dich_pkg.sv
/*
 * Shared definitions for the drive instruction code handler: register
 * offsets, instruction codes, data keys, reset values and carrier types.
 * Assumes a single 100 MHz clock domain and a 32-bit Avalon-MM slave port.
 */
package dich_pkg;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFF_CODE = 8'h00;
	localparam logic [7:0] OFF_DATA = 8'h04;
	localparam logic [7:0] OFF_RESP = 8'h08;
	localparam logic [7:0] OFF_STAT = 8'h0C;
	localparam logic [7:0] OFF_MONA = 8'h10;
	localparam logic [7:0] OFF_FCMD = 8'h14;
	localparam logic [7:0] OFF_MON3 = 8'h18;
	localparam logic [7:0] OFF_MON6 = 8'h24;
	localparam logic [7:0] OFF_RES1 = 8'h28;
	localparam logic [7:0] OFF_RES6 = 8'h3C;
	localparam logic [7:0] OFF_CTRL = 8'h40;

	// ----------------------------------------------------------------
	// Instruction codes
	// ----------------------------------------------------------------
	localparam logic [7:0] IC_PRD_LAST = 8'h63;
	localparam logic [7:0] IC_PWR_FIRST = 8'h80;
	localparam logic [7:0] IC_PWR_LAST = 8'hE3;
	localparam logic [7:0] IC_SEL_RD = 8'h6C;
	localparam logic [7:0] IC_FRAM_RD = 8'h6D;
	localparam logic [7:0] IC_FNV_RD = 8'h6E;
	localparam logic [7:0] IC_OFREQ_RD = 8'h6F;
	localparam logic [7:0] IC_OCUR_RD = 8'h70;
	localparam logic [7:0] IC_OVOLT_RD = 8'h71;
	localparam logic [7:0] IC_SPMON_RD = 8'h72;
	localparam logic [7:0] IC_SPSEL_RD = 8'h73;
	localparam logic [7:0] IC_EXT_RD = 8'h7F;
	localparam logic [7:0] IC_SEL_WR = 8'hEC;
	localparam logic [7:0] IC_FRAM_WR = 8'hED;
	localparam logic [7:0] IC_FNV_WR = 8'hEE;
	localparam logic [7:0] IC_SPSEL_WR = 8'hF3;
	localparam logic [7:0] IC_FAULT_CLR = 8'hF4;
	localparam logic [7:0] IC_PCLEAR = 8'hFC;
	localparam logic [7:0] IC_DRV_RST = 8'hFD;
	localparam logic [7:0] IC_EXT_WR = 8'hFF;

	// ----------------------------------------------------------------
	// Data keys and limits
	// ----------------------------------------------------------------
	localparam logic [15:0] KEY_9696 = 16'h9696;
	localparam logic [15:0] KEY_5A5A = 16'h5A5A;
	localparam logic [15:0] KEY_9966 = 16'h9966;
	localparam logic [15:0] KEY_55AA = 16'h55AA;
	localparam logic [15:0] FREQ_MAX = 16'hE678;
	localparam logic [15:0] VAL_8888 = 16'hFFF0;
	localparam logic [15:0] VAL_9999 = 16'hFFFF;
	localparam logic [15:0] SAT_MAX = 16'hFFFF;
	localparam logic [15:0] PR52_FOLLOW = 16'h0064;
	localparam logic [1:0] SEL_MAX = 2'h2;
	localparam logic [6:0] PN_PROT_A = 7'h4D;
	localparam logic [6:0] PN_PROT_B = 7'h4F;
	localparam logic [6:0] PN_MONSEL = 7'h34;
	localparam logic [7:0] EXT_BANK1 = 8'h01;
	localparam logic [7:0] EXT_BANK9 = 8'h09;
	localparam logic [7:0] MC_NONE = 8'h00;
	localparam logic [7:0] MC_FREQ = 8'h01;
	localparam logic [7:0] MC_CURR = 8'h02;
	localparam logic [7:0] MC_VOLT = 8'h03;

	// ----------------------------------------------------------------
	// Counts and reset values
	// ----------------------------------------------------------------
	localparam logic [8:0] CLEAR_LAST = 9'h1FF;
	localparam logic [15:0] RST_WORD = 16'h0000;
	localparam logic [7:0] RST_BYTE = 8'h00;

	typedef enum logic [2:0] {
		S_IDLE = 3'b001,
		S_ACK = 3'b010,
		S_CLEAR = 3'b100
	} dich_state_t;

	// Live drive quantities feeding the monitors
	typedef struct packed {
		logic [31:0] outFreq;
		logic [31:0] outCurrent;
		logic [31:0] outVoltage;
	} dich_mon_t;

	// Saturate a 32-bit quantity into one 16-bit word
	function automatic logic [15:0] dichSat(input logic [31:0] v);
		return (v > {16'h0000, SAT_MAX}) ? SAT_MAX : v[15:0];
	endfunction : dichSat

endpackage : dich_pkg

//--- tb/dich_master_model.sv
/*
 * Network master station model: runs Avalon-MM cycles into the handler.
 * Assumes the slave drops waitrequest for one cycle per answer.
 */
`timescale 1ns/1ns
module dich_master_model (
	input wire logic mclk,
	input wire logic waitReq,
	input wire logic [31:0] rdData,
	output logic [7:0] addr,
	output logic rd,
	output logic wr,
	output logic [31:0] wrData
);
	// ------------------------------------------------------------
	// Bus cycle
	// ------------------------------------------------------------
	// Idle levels at time zero
	initial begin
		addr = 8'h00;
		rd = 1'b0;
		wr = 1'b0;
		wrData = 32'h00000000;
	end

	// Request held until waitrequest is sampled low, then released
	task automatic xfer(input bit isWr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge mclk);
		addr <= a;
		rd <= !isWr;
		wr <= isWr;
		wrData <= d;
		do @(posedge mclk); while (waitReq !== 1'b0);
		q = rdData;
		rd <= 1'b0;
		wr <= 1'b0;
		// Stale data would hide a slave that samples late
		wrData <= ~d;
	endtask : xfer
endmodule : dich_master_model

//--- tb/drive_instruction_code_handler_tb_top.sv
/*
 * Self-checking bench: master model drives codes, an integer model of
 * parameters and frequency predicts their answers; other checks use fixed values.
 * Assumes the handler's register map and timing from dich_pkg.
 */
`timescale 1ns/1ns
module drive_instruction_code_handler_tb_top;
	import dich_pkg::*;
	logic mclk = 1'b0;
	logic reset_n = 1'b0;
	logic running = 1'b0;
	logic powerFail = 1'b0;
	dich_mon_t monIn = '0;
	logic [7:0] addr;
	logic rd;
	logic wr;
	logic waitReq;
	logic [31:0] wrData;
	logic [31:0] rdData;
	logic [31:0] r;
	logic [15:0] setFreqRam;
	logic fcP;
	logic rsP;
	logic nvP;
	logic j;
	int error_cnt = 0;
	int tests_run = 0;
	int fcN = 0;
	int rsN = 0;
	int nvN = 0;
	int prm [int];

	// ------------------------------------------------------------
	// Clock, pulse counters, instances
	// ------------------------------------------------------------
	always #5 mclk = ~mclk;

	// Pulses are one cycle wide, so counting them catches doubles
	always @(posedge mclk) begin
		fcN += (fcP === 1'b1);
		rsN += (rsP === 1'b1);
		nvN += (nvP === 1'b1);
	end

	dich_core dut_u (.mclk(mclk), .reset_n(reset_n), .avs_address(addr), .avs_read(rd),
		.avs_write(wr), .avs_writedata(wrData), .avs_readdata(rdData),
		.avs_waitrequest(waitReq), .monIn(monIn), .running(running),
		.powerFail(powerFail), .setFreqRam(setFreqRam), .faultClearPulse(fcP),
		.driveResetPulse(rsP), .nvStorePulse(nvP));

	dich_master_model mst_u (.mclk(mclk), .waitReq(waitReq), .rdData(rdData),
		.addr(addr), .rd(rd), .wr(wr), .wrData(wrData));

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic summarize();
		$display("tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : summarize

	// Data word first, then code; leaves result in r, refusal in j
	task automatic cmd(input logic [7:0] c, input logic [15:0] d);
		logic [31:0] q;
		mst_u.xfer(1'b1, OFF_DATA, {16'h0000, d}, q);
		mst_u.xfer(1'b1, OFF_CODE, {24'h000000, c}, q);
		mst_u.xfer(1'b0, OFF_STAT, 32'h00000000, q);
		j = q[0];
		mst_u.xfer(1'b0, OFF_RESP, 32'h00000000, r);
	endtask : cmd

	task automatic rg(input bit isWr, input logic [7:0] a, input logic [15:0] d);
		mst_u.xfer(isWr, a, {16'h0000, d}, r);
	endtask : rg

	// Watchdog: the longest run is well under this span
	initial begin
		repeat (20000) @(posedge mclk);
		error_cnt++;
		summarize();
	end

	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		logic [7:0] wc [4];
		logic [15:0] d;
		int f;
		int cur;
		int vlt;
		int n;
		wc = '{8'h80, 8'h85, 8'h86, 8'hE3};
		void'($urandom(35205));
		repeat (4) @(posedge mclk);
		reset_n <= 1'b1;
		// Clear first: the parameter store has no reset
		cmd(IC_PCLEAR, KEY_9696);
		chk(j, 1'b0);
		cmd(IC_EXT_RD, 16'h0000);
		chk(r, 32'h0);
		$display("test clear done");
		// Volatile writes for repeated updates, store only once
		f = $urandom_range(32'hE678);
		cmd(IC_FRAM_WR, f[15:0]);
		chk(setFreqRam, f);
		cmd(IC_FNV_WR, FREQ_MAX);
		chk(nvN, 1);
		cmd(IC_FRAM_WR, 16'hE679);
		chk({j, setFreqRam}, {1'b1, FREQ_MAX});
		$display("test frequency done");
		for (int i = 0; i < 4; i++) begin
			d = (i == 1) ? VAL_8888 : (i == 2) ? VAL_9999 : 16'($urandom);
			cmd(wc[i], d);
			prm[wc[i] & 8'h7F] = d;
		end
		for (int i = 0; i < 4; i++) begin
			cmd(wc[i] & 8'h7F, 16'h0000);
			chk(r, prm[wc[i] & 8'h7F]);
		end
		cmd(8'hCD, 16'h0001);
		chk(j, 1'b1);
		cmd(8'h4D, 16'h0000);
		chk(r, 32'h0);
		cmd(IC_SEL_WR, 16'h0002);
		chk(j, 1'b1);
		// Extended setting 9 selected before reaching bias and gain
		cmd(IC_EXT_WR, {8'h00, EXT_BANK9});
		for (int s = 0; s < 4; s++) begin
			cmd(IC_SEL_WR, 16'(s));
			chk(j, s > 2);
		end
		cmd(IC_SEL_RD, 16'h0000);
		chk(r, 32'h2);
		cmd(8'h91, 16'h0123);
		cmd(8'h11, 16'h0000);
		chk(r, 32'h0123);
		cmd(IC_SPSEL_WR, 16'hAB02);
		cmd(IC_SPSEL_RD, 16'h0000);
		chk(r, 32'h02);
		cmd(IC_PCLEAR, KEY_5A5A);
		cmd(IC_SPSEL_RD, 16'h0000);
		chk(r, 32'h0);
		$display("test parameters done");
		cmd(IC_FAULT_CLR, KEY_5A5A);
		chk(fcN, 0);
		cmd(IC_FAULT_CLR, KEY_9696);
		chk(fcN, 1);
		cmd(IC_DRV_RST, KEY_9696);
		chk(rsN, 1);
		$display("test pulses done");
		// Monitors with a frequency above one word
		cur = $urandom_range(32'hFFFF);
		vlt = $urandom_range(32'hFFFF);
		monIn <= '{32'h00012345, cur, vlt};
		rg(1'b1, OFF_MONA, 16'h0102);
		rg(1'b1, OFF_MON3, 16'h0003);
		rg(1'b0, OFF_RES1, 16'h0000);
		chk(r, cur);
		rg(1'b0, OFF_RES1 + 8'h04, 16'h0000);
		chk(r, 32'hFFFF);
		rg(1'b0, OFF_RES1 + 8'h08, 16'h0000);
		chk(r, vlt);
		rg(1'b1, OFF_MONA, 16'h0000);
		rg(1'b0, OFF_RES1, 16'h0000);
		chk(r, 32'h0);
		rg(1'b0, OFF_RES1 + 8'h04, 16'h0000);
		chk(r, 32'hFFFF);
		// Current above one word in the high position must saturate
		monIn <= '{32'h00012345, 32'h00010000, vlt};
		rg(1'b1, OFF_MONA, 16'h0200);
		rg(1'b0, OFF_RES1 + 8'h04, 16'h0000);
		chk(r, 32'hFFFF);
		rg(1'b0, 8'h44, 16'h0000);
		chk(r, 32'h0);
		$display("test monitors done");
		cmd(8'hB4, PR52_FOLLOW);
		cmd(IC_FRAM_WR, 16'h0ABC);
		cmd(IC_OFREQ_RD, 16'h0000);
		chk(r, 32'h0ABC);
		running <= 1'b1;
		repeat (4) @(posedge mclk);
		cmd(IC_OFREQ_RD, 16'h0000);
		chk(r, 32'hFFFF);
		$display("test monitor follow done");
		// RAM-only setting survives preserving clears unless power drops mid clear
		n = nvN;
		rg(1'b1, OFF_CTRL, 16'h0001);
		cmd(8'h81, 16'h0042);
		chk(nvN, n);
		cmd(IC_PCLEAR, KEY_55AA);
		rg(1'b0, OFF_CTRL, 16'h0000);
		chk(r, 32'h1);
		powerFail <= 1'b1;
		cmd(IC_PCLEAR, KEY_5A5A);
		rg(1'b0, OFF_CTRL, 16'h0000);
		chk(r, 32'h0);
		powerFail <= 1'b0;
		rg(1'b1, OFF_CTRL, 16'h0001);
		cmd(IC_PCLEAR, KEY_9966);
		rg(1'b0, OFF_CTRL, 16'h0000);
		chk(r, 32'h0);
		$display("test clear keys done");
		summarize();
	end
endmodule : drive_instruction_code_handler_tb_top
